/* shared/eth_status_pkg.sv */
// shared constants for the receive buffer count and status block
package eth_status_pkg;
    // register offsets (byte addresses, word aligned)
    localparam logic [7:0] STATUS_OFS    = 8'h00; // ethernet_controller_status
    localparam logic [7:0] CONTROL_OFS   = 8'h04; // ethernet_control_one
    localparam logic [7:0] IRQ_EN_OFS    = 8'h08; // ethernet_irq_enable_reg
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h0c; // sticky event status
    localparam logic [7:0] RESET_REG_OFS = 8'h10; // controller_reset_register
    // status register fields
    localparam int COUNT_LSB      = 16;
    localparam int COUNT_W        = 8;
    localparam int MOD_BUSY_BIT   = 7;
    localparam int TX_BUSY_BIT    = 6;
    localparam int RX_BUSY_BIT    = 5;
    // control register fields
    localparam int MOD_ON_BIT     = 15;
    localparam int FLOW_EN_BIT    = 1;
    localparam int DEC_BIT        = 0;
    // event bits shared by the mask and sticky status registers
    localparam int EV_PEND_BIT    = 0;
    localparam int EV_FULL_BIT    = 1;
    localparam int EV_W           = 2;
    // count limits and reset values
    localparam logic [7:0] COUNT_MAX   = 8'hff;
    localparam logic [7:0] COUNT_RST   = 8'h00;
    localparam logic [1:0] EV_RST      = 2'h0;
    // cycles the module stays busy after switch-off with no traffic
    localparam int DRAIN_NS       = 40;
    localparam int CLK_NS         = 4;
    localparam int DRAIN_CYC      = (DRAIN_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* logic/pin_sync.sv */
// three flop synchroniser with agreement filter for one level input
`timescale 1ns/1ps
module pin_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] stage_ff;   // stage 0 read only by stage 1
    logic [2:0] nxt_stage;
    logic       out_ff;     // filtered level
    logic       nxt_out;

    // shift and accept a change once the last two agree
    always_comb begin
        nxt_stage = {stage_ff[1:0], din};
        nxt_out   = (stage_ff[2] == stage_ff[1]) ? stage_ff[2] : out_ff;
    end

    // registers only
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stage_ff <= 3'h0;
            out_ff   <= 1'b0;
        end else begin
            stage_ff <= nxt_stage;
            out_ff   <= nxt_out;
        end
    end

    assign dout = out_ff;
endmodule

/* logic/eth_rx_buffer_count_status.sv */
// receive buffer count, busy flags, control and interrupt registers
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module eth_rx_buffer_count_status #(
    parameter int DESC_W = 8 // width of per-packet descriptor count
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [7:0]        regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [31:0]       regRdata,
    input  wire logic              pktDone,     // good packet, one cycle
    input  wire logic [DESC_W-1:0] pktDescs,    // descriptors it used
    input  wire logic              txActive,    // transmit engine working
    input  wire logic              rxActive,    // receive engine working
    input  wire logic              rxPinActive, // raw receive pin activity
    output logic                   rxStall,     // halt receive processing
    output logic                   moduleOn,    // module enable
    output logic                   pendFlag,    // packet pending level
    output logic                   irq
);
    //////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]  count_ff;      // packet_buffer_count
    logic [7:0]  nxt_count;
    logic        on_ff;         // module enable
    logic        nxt_on;
    logic        flow_ff;       // automatic flow control enable
    logic        nxt_flow;
    logic [1:0]  irqEn_ff;      // event mask
    logic [1:0]  nxt_irqEn;
    logic [1:0]  irqStat_ff;    // sticky events
    logic [1:0]  nxt_irqStat;
    logic        transmit_busy_flag_ff;
    logic        nxt_transmit_busy_flag;
    logic        receive_busy_flag_ff;
    logic        nxt_receive_busy_flag;
    logic [3:0]  drain_ff;      // post switch-off drain counter
    logic [3:0]  nxt_drain;
    logic        busy_ff;       // module_busy_flag
    logic        nxt_busy;
    logic        stall_ff;
    logic        nxt_stall;
    logic        pend_ff;
    logic        nxt_pend;
    logic        irqOut_ff;
    logic        nxt_irqOut;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        rxPinSync;     // filtered raw pin activity

    // helper wires
    logic        decReq;
    logic        incReq;
    logic        rstWr;
    logic [8:0]  sum;
    logic [1:0]  events;

    localparam logic [3:0] DRAIN_LOAD = 4'(eth_status_pkg::DRAIN_CYC);

    //////////////////////////////////////////////////////////////////////////
    // pin activity sync; raw pin keeps receive busy alive
    pin_sync u_rx_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (rxPinActive),
        .dout (rxPinSync)
    );

    //////////////////////////////////////////////////////////////////////////
    // decode: decrement is a write strobe, never a stored bit
    always_comb begin
        decReq = regWr && regAddr == eth_status_pkg::CONTROL_OFS &&
                 regWdata[eth_status_pkg::DEC_BIT];
        rstWr  = regWr && regAddr == eth_status_pkg::RESET_REG_OFS;
        incReq = pktDone && !stall_ff;
    end

    //////////////////////////////////////////////////////////////////////////
    // buffer count next value
    always_comb begin
        sum       = {1'b0, count_ff} + {{(9-DESC_W){1'b0}}, pktDescs};
        nxt_count = count_ff;
        if (rstWr) begin
            nxt_count = eth_status_pkg::COUNT_RST;
        end else if (incReq && decReq) begin
            nxt_count = count_ff;
        end else if (incReq) begin
            // saturate rather than wrap
            nxt_count = sum[8] ? eth_status_pkg::COUNT_MAX : sum[7:0];
        end else if (decReq) begin
            if (count_ff != 8'h00) begin
                nxt_count = count_ff - 8'h01;
            end
        end
        // enable bit deliberately absent here
    end

    //////////////////////////////////////////////////////////////////////////
    // control, mask and busy next values
    always_comb begin
        nxt_on     = on_ff;
        nxt_flow   = flow_ff;
        nxt_irqEn  = irqEn_ff;
        if (regWr && regAddr == eth_status_pkg::CONTROL_OFS) begin
            nxt_on   = regWdata[eth_status_pkg::MOD_ON_BIT];
            nxt_flow = regWdata[eth_status_pkg::FLOW_EN_BIT];
        end
        if (regWr && regAddr == eth_status_pkg::IRQ_EN_OFS) begin
            nxt_irqEn = regWdata[eth_status_pkg::EV_W-1:0];
        end
        // transmit busy follows its engine, receive busy its engine or the synced pin; off clears both
        nxt_transmit_busy_flag = on_ff && txActive;
        nxt_receive_busy_flag = on_ff && (rxActive || rxPinSync);
        // drain timer restarts while on or either engine is active; pin activity does not restart it
        if (on_ff || txActive || rxActive) begin
            nxt_drain = DRAIN_LOAD;
        end else if (drain_ff != 4'h0) begin
            nxt_drain = drain_ff - 4'h1;
        end else begin
            nxt_drain = 4'h0;
        end
        nxt_busy = on_ff || txActive || rxActive || drain_ff != 4'h0;
        // stall only when flow control on and count full
        nxt_stall = nxt_flow && nxt_count == eth_status_pkg::COUNT_MAX;
        nxt_pend  = nxt_count != 8'h00;
    end

    //////////////////////////////////////////////////////////////////////////
    // sticky events: set beats the clear-on-read
    always_comb begin
        events = 2'h0;
        events[eth_status_pkg::EV_PEND_BIT] = nxt_pend && !pend_ff;
        events[eth_status_pkg::EV_FULL_BIT] = nxt_stall && !stall_ff;
        nxt_irqStat = irqStat_ff;
        if (regRd && regAddr == eth_status_pkg::IRQ_STAT_OFS) begin
            nxt_irqStat = 2'h0;
        end
        nxt_irqStat = nxt_irqStat | events;
        // pending interrupt is a level on the flag itself
        nxt_irqOut = |(nxt_irqStat & nxt_irqEn) ||
                     (nxt_pend && nxt_irqEn[eth_status_pkg::EV_PEND_BIT]);
    end

    //////////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = 32'h0;
        if (regRd) begin
            case (regAddr)
                eth_status_pkg::STATUS_OFS: begin
                    nxt_rdata[eth_status_pkg::COUNT_LSB +: 8] = count_ff;
                    nxt_rdata[eth_status_pkg::MOD_BUSY_BIT]  = busy_ff;
                    nxt_rdata[eth_status_pkg::TX_BUSY_BIT]   = transmit_busy_flag_ff;
                    nxt_rdata[eth_status_pkg::RX_BUSY_BIT]   = receive_busy_flag_ff;
                end
                eth_status_pkg::CONTROL_OFS: begin
                    nxt_rdata[eth_status_pkg::MOD_ON_BIT]  = on_ff;
                    nxt_rdata[eth_status_pkg::FLOW_EN_BIT] = flow_ff;
                end
                eth_status_pkg::IRQ_EN_OFS: begin
                    nxt_rdata[1:0] = irqEn_ff;
                end
                eth_status_pkg::IRQ_STAT_OFS: begin
                    nxt_rdata[1:0] = irqStat_ff;
                end
                default: begin
                    nxt_rdata = 32'h0;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // registers only
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_ff   <= eth_status_pkg::COUNT_RST;
            on_ff      <= 1'b0;
            flow_ff    <= 1'b0;
            irqEn_ff   <= eth_status_pkg::EV_RST;
            irqStat_ff <= eth_status_pkg::EV_RST;
            transmit_busy_flag_ff  <= 1'b0;
            receive_busy_flag_ff  <= 1'b0;
            drain_ff   <= 4'h0;
            busy_ff    <= 1'b0;
            stall_ff   <= 1'b0;
            pend_ff    <= 1'b0;
            irqOut_ff  <= 1'b0;
            rdata_ff   <= 32'h0;
        end else begin
            count_ff   <= nxt_count;
            on_ff      <= nxt_on;
            flow_ff    <= nxt_flow;
            irqEn_ff   <= nxt_irqEn;
            irqStat_ff <= nxt_irqStat;
            transmit_busy_flag_ff  <= nxt_transmit_busy_flag;
            receive_busy_flag_ff  <= nxt_receive_busy_flag;
            drain_ff   <= nxt_drain;
            busy_ff    <= nxt_busy;
            stall_ff   <= nxt_stall;
            pend_ff    <= nxt_pend;
            irqOut_ff  <= nxt_irqOut;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign regRdata = rdata_ff;
    assign rxStall  = stall_ff;
    assign moduleOn = on_ff;
    assign pendFlag = pend_ff;
    assign irq      = irqOut_ff;

    //////////////////////////////////////////////////////////////////////////
    // checks
    count_sat_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(count_ff) == 8'hff && count_ff == 8'h00 |-> $past(rstWr)
        ) else $error("count wrapped from max");
    count_floor_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(count_ff) == 8'h00 && $past(decReq) && !$past(incReq)
        |-> count_ff == 8'h00) else $error("count rolled under");
    both_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        incReq && decReq && !rstWr |=> $stable(count_ff)
        ) else $error("count moved on clash");
    dec_step_a: assert property (@(posedge clk) disable iff (!nrst)
        decReq && !incReq && !rstWr && count_ff != 8'h00
        |=> count_ff == $past(count_ff) - 8'h01) else $error("bad dec");
    inc_add_a: assert property (@(posedge clk) disable iff (!nrst)
        incReq && !decReq && !rstWr && sum[8] == 1'b0
        |=> count_ff == $past(sum[7:0])) else $error("bad inc");
    rst_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        rstWr |=> count_ff == 8'h00) else $error("reset write kept count");
    stall_full_a: assert property (@(posedge clk) disable iff (!nrst)
        rxStall == (flow_ff && count_ff == 8'hff)
        ) else $error("stall mismatch");
    no_stall_a: assert property (@(posedge clk) disable iff (!nrst)
        !flow_ff |-> !rxStall) else $error("stall without flow");
    pend_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        pendFlag == (count_ff != 8'h00)) else $error("pending mismatch");
    off_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        on_ff && !nxt_on && !incReq && !decReq && !rstWr
        |=> $stable(count_ff)) else $error("off cleared count");
    busy_on_a: assert property (@(posedge clk) disable iff (!nrst)
        on_ff |=> busy_ff) else $error("busy low while on");
    off_clr_a: assert property (@(posedge clk) disable iff (!nrst)
        !on_ff |=> !transmit_busy_flag_ff && !receive_busy_flag_ff) else $error("busy kept off");

    //////////////////////////////////////////////////////////////////////////
    // decode and drain checks
    // decrement bit is never stored, so it always reads back clear
    dec_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
        regRd && regAddr == eth_status_pkg::CONTROL_OFS
        |=> !regRdata[eth_status_pkg::DEC_BIT]) else $error("dec stuck");
    // busy has to fall once the drain timer has run out
    busy_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        !on_ff && !txActive && !rxActive && drain_ff == 4'h0
        |=> !busy_ff) else $error("busy stuck idle");
endmodule

/* tb/rx_dma_model.sv */
// receive dma stand-in: offers packets, holds one while receive stalls
`timescale 1ns/1ps
module rx_dma_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       rxStall,
    input  wire logic       sendReq,
    input  wire logic [7:0] sendDescs,
    output logic            pktDone,
    output logic [7:0]      pktDescs
);
    // one packet a request; a refused packet is offered again
    always @(posedge clk) begin
        if (!nrst) begin
            pktDone  <= 1'b0;
            pktDescs <= 8'h00;
        end else if (sendReq) begin
            pktDone  <= 1'b1;
            pktDescs <= sendDescs;
        end else if (pktDone && rxStall) begin
            pktDone  <= 1'b1;
        end else begin
            pktDone  <= 1'b0;
            pktDescs <= ~pktDescs; // never a stale count
        end
    end
endmodule

/* tb/eth_rx_buffer_count_status_bench.sv */
// self-checking bench for the receive buffer count and status block
`timescale 1ns/1ps
module eth_rx_buffer_count_status_bench;
    localparam logic [7:0] STA = eth_status_pkg::STATUS_OFS;
    localparam logic [7:0] CTL = eth_status_pkg::CONTROL_OFS;
    localparam logic [7:0] IEN = eth_status_pkg::IRQ_EN_OFS;
    localparam logic [7:0] IST = eth_status_pkg::IRQ_STAT_OFS;
    localparam logic [7:0] RST = eth_status_pkg::RESET_REG_OFS;
    logic        clk, nrst, regWr, regRd, sendReq, pktDone;
    logic        txActive, rxActive, rxPinActive;
    logic        rxStall, moduleOn, pendFlag, irq, flowRef;
    logic [7:0]  regAddr, sendDescs, pktDescs, cntRef;
    logic [31:0] regWdata, regRdata, ctlWord, d, r;
    int          errorCnt, checks, cyc, seed, rv;

    eth_rx_buffer_count_status i_dut (.clk(clk), .nrst(nrst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .pktDone(pktDone),
        .pktDescs(pktDescs), .txActive(txActive), .rxActive(rxActive),
        .rxPinActive(rxPinActive), .rxStall(rxStall),
        .moduleOn(moduleOn), .pendFlag(pendFlag), .irq(irq));
    rx_dma_model i_dma (.clk(clk), .nrst(nrst), .rxStall(rxStall),
        .sendReq(sendReq), .sendDescs(sendDescs), .pktDone(pktDone),
        .pktDescs(pktDescs));

    // expected count: clear beats all, inc with dec holds, both saturate
    function automatic logic [7:0] next_cnt(input logic [7:0] c,
        input logic inc, input logic [7:0] n, input logic dec,
        input logic clr);
        logic [8:0] sum;
        sum = {1'b0, c} + {1'b0, n};
        if (clr) return 8'h00;
        if (inc && dec) return c;
        if (inc) return sum[8] ? 8'hff : sum[7:0];
        if (dec) return (c == 8'h00) ? 8'h00 : c - 8'h01;
        return c;
    endfunction

    // reference reads the inputs the dut samples at the same edge
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errorCnt++;
            tally_and_finish();
        end
        if (!nrst) begin
            cntRef = 8'h00;
            flowRef = 1'b0;
        end else begin
            cntRef = next_cnt(cntRef, pktDone && !(flowRef && cntRef == 8'hff),
                pktDescs, regWr && regAddr == CTL && regWdata[0],
                regWr && regAddr == RST);
            if (regWr && regAddr == CTL) flowRef = regWdata[1];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= v;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // packet and/or decrement, both landing at the same edge
    task automatic op(input logic pk, input logic dc, input logic [7:0] n);
        @(posedge clk);
        sendReq   <= pk;
        sendDescs <= n;
        @(posedge clk);
        sendReq  <= 1'b0;
        regAddr  <= CTL;
        regWdata <= ctlWord | 32'h1;
        regWr    <= dc;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask
    task automatic chk_cnt();
        rd(STA, d);
        chk({24'h0, d[23:16]}, {24'h0, cntRef});
        chk({31'h0, pendFlag}, {31'h0, cntRef != 8'h00});
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // scenarios
    initial begin
        seed = 32'h8aad;
        errorCnt = 0;
        checks = 0;
        cyc = 0;
        nrst = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        sendReq = 1'b0;
        sendDescs = 8'h00;
        txActive = 1'b0;
        rxActive = 1'b0;
        rxPinActive = 1'b0;
        ctlWord = 32'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        // switch on, plain increments, clash, random mix
        ctlWord = 32'h8000;
        wr(CTL, ctlWord);
        rd(CTL, d);
        chk(d, 32'h00008000);
        chk({31'h0, moduleOn}, 32'h1);
        op(1'b1, 1'b0, 8'h03);
        chk_cnt();
        op(1'b1, 1'b1, 8'h05);
        chk_cnt();
        repeat (60) begin
            rv = $random(seed);
            op(rv[0], rv[1], rv[15:8]);
            chk_cnt();
        end
        $display("test random mix done");
        // saturation at the top, clear, floor at zero
        repeat (3) op(1'b1, 1'b0, 8'hf0);
        chk_cnt();
        chk({24'h0, d[23:16]}, 32'h000000ff);
        wr(RST, 32'h0);
        chk_cnt();
        op(1'b0, 1'b1, 8'h00);
        chk_cnt();
        chk({24'h0, d[23:16]}, 32'h00000000);
        $display("test limits done");
        // flow control: stall at full, release by decrement
        ctlWord = 32'h8002;
        wr(CTL, ctlWord);
        repeat (2) op(1'b1, 1'b0, 8'hc0);
        chk_cnt();
        settle(1);
        chk({31'h0, rxStall}, {31'h0, flowRef && cntRef == 8'hff});
        op(1'b1, 1'b0, 8'h05);
        op(1'b0, 1'b1, 8'h00);
        settle(2);
        chk_cnt();
        // pending interrupt follows the count once sticky bits are read
        wr(IEN, 32'h1);
        rd(IST, d);
        settle(2);
        chk({31'h0, irq}, {31'h0, cntRef != 8'h00});
        $display("test flow control done");
        // flow control off: packets keep counting and saturate
        ctlWord = 32'h8000;
        wr(CTL, ctlWord);
        settle(2);
        chk({31'h0, rxStall}, 32'h0);
        repeat (3) op(1'b1, 1'b0, 8'h90);
        chk_cnt();
        chk({24'h0, d[23:16]}, 32'h000000ff);
        // busy flags follow the transmit engine and the receive pin activity
        @(posedge clk);
        txActive <= 1'b1;
        rxPinActive <= 1'b1;
        settle(8);
        rd(STA, d);
        chk({29'h0, d[7:5]}, 32'h00000007);
        @(posedge clk);
        txActive <= 1'b0;
        rxPinActive <= 1'b0;
        // switch off: count kept, decrements still work, busy drains
        ctlWord = 32'h0;
        wr(CTL, ctlWord);
        op(1'b0, 1'b1, 8'h00);
        chk_cnt();
        settle(16);
        rd(STA, d);
        chk({29'h0, d[7:5]}, 32'h0);
        $display("test switch off done");
        // reset in mid run clears everything
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        chk_cnt();
        chk({31'h0, irq}, 32'h0);
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule
